// [trs_defs.vh]
// Summary of operation
// [RULE1] torque path active when control mode is 2
// [RULE2] source select: A, B, A+B, switched, comm
// [RULE3] main source 0 selects keypad digital setting
// [RULE4] keypad setpoint signed 0.1 percent, immediate effect
// [RULE5] auxiliary B configured like main A
// [RULE6] switch input off selects A, on selects B
// [RULE7] source 4 uses comm setpoint, 0.001 percent
// [RULE8] host writes comm setpoint over link only
// [RULE9] invert input active reverses torque direction
// [RULE10] setting, sign, invert each toggle rotation
// [RULE11] source selects change only while motor stopped
`ifndef TRS_DEFS_VH
`define TRS_DEFS_VH
// register byte offsets
`define TRS_OFS_MODE 8'h00
`define TRS_OFS_SRC 8'h04
`define TRS_OFS_KEYPAD_A 8'h08
`define TRS_OFS_KEYPAD_B 8'h0c
`define TRS_OFS_COMM 8'h10
`define TRS_OFS_STATUS 8'h14
`define TRS_OFS_TORQUE 8'h18
// field positions
`define TRS_MODE_LSB 0
`define TRS_ROTDIR_BIT 8
`define TRS_SEL_LSB 0
`define TRS_MAINSRC_BIT 8
`define TRS_AUXSRC_BIT 12
// field values
`define TRS_MODE_TORQUE 2'h2
`define TRS_SEL_A 3'h0
`define TRS_SEL_B 3'h1
`define TRS_SEL_SUM 3'h2
`define TRS_SEL_SWITCH 3'h3
`define TRS_SEL_COMM 3'h4
`define TRS_SRC_DIGITAL 1'h0
// limits, keypad in 0.1 percent, comm in 0.001 percent
`define TRS_KEYPAD_MAX 16'sh0fa0
`define TRS_COMM_MAX 32'sh000186a0
`define TRS_KEYPAD_SCALE 32'sh00000064
// reset values
`define TRS_RST_MODE 2'h0
`define TRS_RST_SEL 3'h0
`define TRS_RST_KEYPAD 16'h0000
`define TRS_RST_COMM 32'h00000000
// bus responses
`define TRS_RESP_OKAY 2'h0
`define TRS_RESP_SLVERR 2'h2
`endif

// [trs_top.v]
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "trs_defs.vh"
module trs_top (
  // clock and reset
  input wire mclk,
  input wire srst,
  // drive state, same clock
  input wire run_active,
  // digital input pins
  input wire cmd_sel_in,
  input wire torque_direction_invert,
  // axi4-lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // axi4-lite write response
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // axi4-lite read data
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  // torque reference outputs
  output reg torque_mode_active,
  output reg signed [31:0] torque_ref_out,
  output reg rotate_ccw,
  output reg rotate_cw
);

  // pin synchronisers
  reg [1:0] cmd_sel_sync_reg;
  reg [1:0] inv_sync_reg;
  always @(posedge mclk) begin
    if (srst) begin
      cmd_sel_sync_reg <= 2'h0;
      inv_sync_reg <= 2'h0;
    end else begin
      cmd_sel_sync_reg <= {cmd_sel_sync_reg[0], cmd_sel_in};
      inv_sync_reg <= {inv_sync_reg[0], torque_direction_invert};
    end
  end
  wire cmd_sel = cmd_sel_sync_reg[1];
  wire dir_inv = inv_sync_reg[1];

  // software registers
  reg [1:0] control_mode_select_reg;
  reg rotation_direction_setting_reg;
  reg [2:0] torque_ref_source_select_reg;
  reg main_torque_source_reg;
  reg aux_torque_source_reg;
  reg signed [15:0] keypad_a_reg;
  reg signed [15:0] keypad_b_reg;
  reg signed [31:0] comm_torque_setpoint_reg;

  // write channel capture
  reg aw_have_reg;
  reg w_have_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_reg & ~s_axi_bvalid;
  wire do_write = aw_have_reg & w_have_reg;

  wire [31:0] strb_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                           {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  // readback of current register words
  reg [31:0] mode_word;
  reg [31:0] src_word;
  always @* begin
    mode_word = 32'h00000000;
    mode_word[`TRS_MODE_LSB +: 2] = control_mode_select_reg;
    mode_word[`TRS_ROTDIR_BIT] = rotation_direction_setting_reg;
    src_word = 32'h00000000;
    src_word[`TRS_SEL_LSB +: 3] = torque_ref_source_select_reg;
    src_word[`TRS_MAINSRC_BIT] = main_torque_source_reg;
    src_word[`TRS_AUXSRC_BIT] = aux_torque_source_reg;
  end

  function [31:0] merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [31:0] mask;
    begin
      merge = (old_word & ~mask) | (new_word & mask);
    end
  endfunction

  // low half is the signed setpoint, saturated to plus or minus 400.0
  function signed [15:0] clamp_keypad;
    input [31:0] w;
    begin
      if ($signed(w[15:0]) > `TRS_KEYPAD_MAX)
        clamp_keypad = `TRS_KEYPAD_MAX;
      else if ($signed(w[15:0]) < -`TRS_KEYPAD_MAX)
        clamp_keypad = -`TRS_KEYPAD_MAX;
      else
        clamp_keypad = w[15:0];
    end
  endfunction

  reg [31:0] wr_word;
  reg wr_hit;
  always @* begin
    wr_word = 32'h00000000;
    wr_hit = 1'b1;
    case (aw_addr_reg)
      `TRS_OFS_MODE: wr_word = merge(mode_word, w_data_reg, strb_mask);
      `TRS_OFS_SRC: wr_word = merge(src_word, w_data_reg, strb_mask);
      `TRS_OFS_KEYPAD_A: wr_word = merge({{16{keypad_a_reg[15]}},
        keypad_a_reg}, w_data_reg, strb_mask);
      `TRS_OFS_KEYPAD_B: wr_word = merge({{16{keypad_b_reg[15]}},
        keypad_b_reg}, w_data_reg, strb_mask);
      `TRS_OFS_COMM: wr_word = merge(comm_torque_setpoint_reg,
        w_data_reg, strb_mask);
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TRS_RESP_OKAY;
      control_mode_select_reg <= `TRS_RST_MODE;
      rotation_direction_setting_reg <= 1'b0;
      torque_ref_source_select_reg <= `TRS_RST_SEL;
      main_torque_source_reg <= `TRS_SRC_DIGITAL;
      aux_torque_source_reg <= `TRS_SRC_DIGITAL;
      keypad_a_reg <= `TRS_RST_KEYPAD;
      keypad_b_reg <= `TRS_RST_KEYPAD;
      comm_torque_setpoint_reg <= `TRS_RST_COMM;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `TRS_RESP_OKAY : `TRS_RESP_SLVERR;
        case (aw_addr_reg)
          `TRS_OFS_MODE: begin
            control_mode_select_reg <= wr_word[`TRS_MODE_LSB +: 2];
            rotation_direction_setting_reg <= wr_word[`TRS_ROTDIR_BIT];
          end
          `TRS_OFS_SRC: begin
            if (!run_active) begin // [RULE11]
              torque_ref_source_select_reg <= wr_word[`TRS_SEL_LSB +: 3];
              main_torque_source_reg <= wr_word[`TRS_MAINSRC_BIT];
              aux_torque_source_reg <= wr_word[`TRS_AUXSRC_BIT];
            end
          end
          `TRS_OFS_KEYPAD_A: keypad_a_reg <= clamp_keypad(wr_word); // [RULE4]
          `TRS_OFS_KEYPAD_B: keypad_b_reg <= clamp_keypad(wr_word); // [RULE5]
          `TRS_OFS_COMM: begin
            if ($signed(wr_word) > `TRS_COMM_MAX) // [RULE7]
              comm_torque_setpoint_reg <= `TRS_COMM_MAX;
            else if ($signed(wr_word) < -`TRS_COMM_MAX)
              comm_torque_setpoint_reg <= -`TRS_COMM_MAX;
            else
              comm_torque_setpoint_reg <= wr_word;
          end
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // reference path, all in 0.001 percent units
  wire signed [31:0] ref_a = (main_torque_source_reg == `TRS_SRC_DIGITAL) ?
    {{16{keypad_a_reg[15]}}, keypad_a_reg} * `TRS_KEYPAD_SCALE :
    32'sh00000000; // [RULE3]
  wire signed [31:0] ref_b = (aux_torque_source_reg == `TRS_SRC_DIGITAL) ?
    {{16{keypad_b_reg[15]}}, keypad_b_reg} * `TRS_KEYPAD_SCALE :
    32'sh00000000; // [RULE5]

  reg signed [31:0] ref_sel;
  always @* begin
    case (torque_ref_source_select_reg) // [RULE2]
      `TRS_SEL_A: ref_sel = ref_a;
      `TRS_SEL_B: ref_sel = ref_b;
      `TRS_SEL_SUM: ref_sel = ref_a + ref_b;
      `TRS_SEL_SWITCH: ref_sel = cmd_sel ? ref_b : ref_a; // [RULE6]
      `TRS_SEL_COMM: ref_sel = comm_torque_setpoint_reg; // [RULE7] [RULE8]
      default: ref_sel = 32'sh00000000;
    endcase
  end

  wire torque_mode = (control_mode_select_reg == `TRS_MODE_TORQUE);
  wire ref_neg = ref_sel[31];
  wire dir_ccw_next = ~(rotation_direction_setting_reg ^ ref_neg ^ dir_inv);

  always @(posedge mclk) begin
    if (srst) begin
      torque_mode_active <= 1'b0;
      torque_ref_out <= 32'sh00000000;
      rotate_ccw <= 1'b0;
      rotate_cw <= 1'b0;
    end else begin
      torque_mode_active <= torque_mode; // [RULE1]
      if (!torque_mode) begin
        torque_ref_out <= 32'sh00000000;
        rotate_ccw <= 1'b0;
        rotate_cw <= 1'b0;
      end else begin
        torque_ref_out <= dir_inv ? -ref_sel : ref_sel; // [RULE9]
        rotate_ccw <= (ref_sel != 0) & dir_ccw_next; // [RULE10]
        rotate_cw <= (ref_sel != 0) & ~dir_ccw_next; // [RULE10]
      end
    end
  end

  // read channel
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge mclk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TRS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TRS_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'h0})
        `TRS_OFS_MODE: s_axi_rdata <= mode_word;
        `TRS_OFS_SRC: s_axi_rdata <= src_word;
        `TRS_OFS_KEYPAD_A: s_axi_rdata <= {{16{keypad_a_reg[15]}},
          keypad_a_reg};
        `TRS_OFS_KEYPAD_B: s_axi_rdata <= {{16{keypad_b_reg[15]}},
          keypad_b_reg};
        `TRS_OFS_COMM: s_axi_rdata <= comm_torque_setpoint_reg;
        `TRS_OFS_STATUS: s_axi_rdata <= {27'h0000000, dir_inv, cmd_sel,
          rotate_cw, rotate_ccw, torque_mode_active};
        `TRS_OFS_TORQUE: s_axi_rdata <= torque_ref_out;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `TRS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [trs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module trs_props (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // reference outputs
  input wire logic torque_mode_active,
  input wire logic signed [31:0] torque_ref_out,
  input wire logic rotate_ccw,
  input wire logic rotate_cw
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  AST_OFF_ZERO: assert property (!torque_mode_active [*3] |->
    torque_ref_out == 0 && !rotate_ccw && !rotate_cw) else $error("idle ref");
  AST_ZERO_STILL: assert property (torque_ref_out == 0 |->
    !rotate_ccw && !rotate_cw) else $error("zero ref rotates");
  AST_ONE_DIR: assert property (torque_ref_out != 0 |->
    rotate_ccw != rotate_cw) else $error("direction flags");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read latency");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read hold");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write hold");
  AST_AR_RDY: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without address");
  AST_RST: assert property (disable iff (1'b0) srst |=> !torque_mode_active
    && torque_ref_out == 0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("reset state");
endmodule
bind trs_top trs_props u_props (.mclk, .srst, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .torque_mode_active,
  .torque_ref_out, .rotate_ccw, .rotate_cw);
`default_nettype wire

// [trs_host.sv]
`timescale 1ns/1ps
`default_nettype none
module trs_host (
  // clock
  input wire logic mclk,
  // pin requests
  input wire logic sel_req,
  input wire logic inv_req,
  // digital input pins
  output var logic cmd_sel_in = 1'b0,
  output var logic torque_direction_invert = 1'b0
);
  always @(posedge mclk) begin
    cmd_sel_in <= sel_req;
    torque_direction_invert <= inv_req;
  end
endmodule
`default_nettype wire

// [torque_reference_select_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "trs_defs.vh"
module torque_reference_select_tb;
  typedef struct packed {
    logic rot;
    logic [2:0] sel;
    logic [15:0] ka;
    logic [15:0] kb;
    logic [31:0] cm;
    logic ps;
    logic inv;
  } trs_row_t;
  trs_row_t rows [8] = '{'{0, 0, 16'h0064, 0, 0, 0, 0},
    '{0, 1, 0, 16'hffce, 0, 0, 0}, '{1, 2, 16'h0064, 16'hffce, 0, 0, 1},
    '{0, 3, 16'h0064, 16'h00c8, 0, 0, 0},
    '{0, 3, 16'h0064, 16'h00c8, 0, 1, 0},
    '{0, 4, 16'h0064, 0, 32'hfffe7960, 0, 0}, '{1, 0, 16'h1000, 0, 0, 0, 0},
    '{0, 4, 0, 0, 32'h000186a1, 0, 1}};
  logic mclk = 0, srst = 1, run = 0, sel_req = 0, inv_req = 0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdv;
  logic [1:0] rsp;
  wire awr, wr, bv, arr, rv, tma, ccw, cw, csel, tinv;
  wire [1:0] br, rr;
  wire [31:0] rd;
  wire signed [31:0] tq;
  int failures = 0, n_checks = 0, cyc = 0;
  trs_host u_host (.mclk, .sel_req, .inv_req, .cmd_sel_in(csel),
    .torque_direction_invert(tinv));
  trs_top u_dut (.mclk, .srst, .run_active(run), .cmd_sel_in(csel),
    .torque_direction_invert(tinv), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .torque_mode_active(tma), .torque_ref_out(tq), .rotate_ccw(ccw),
    .rotate_cw(cw));
  initial forever #2 mclk = ~mclk;
  task results;
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      results;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge mclk);
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= d;
    bry <= 1;
    while (!(ta && tw)) begin
      @(posedge mclk);
      if (!ta && awr) begin
        ta = 1'b1;
        awv <= 0;
      end
      if (!tw && wr) begin
        tw = 1'b1;
        wv <= 0;
      end
    end
    do @(posedge mclk); while (!bv);
    rsp = br;
    bry <= 0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge mclk);
    arv <= 1;
    ara <= a;
    rry <= 1;
    do @(posedge mclk); while (!arr);
    arv <= 0;
    do @(posedge mclk); while (!rv);
    rdv = rd;
    rsp = rr;
    rry <= 0;
  endtask
  function automatic logic signed [31:0] lim(input logic signed [31:0] v,
      input logic signed [31:0] m);
    return v > m ? m : (v < -m ? -m : v);
  endfunction
  initial begin
    trs_row_t r;
    logic signed [31:0] a, b, rf, et;
    logic c;
    repeat (2) @(posedge mclk);
    srst <= 0;
    foreach (rows[i]) begin
      r = rows[i];
      sel_req <= r.ps;
      inv_req <= r.inv;
      wr_reg(`TRS_OFS_MODE, {23'h0, r.rot, 8'h02});
      wr_reg(`TRS_OFS_SRC, {29'h0, r.sel});
      wr_reg(`TRS_OFS_KEYPAD_A, {16'h0, r.ka});
      wr_reg(`TRS_OFS_KEYPAD_B, {16'h0, r.kb});
      wr_reg(`TRS_OFS_COMM, r.cm);
      repeat (4) @(posedge mclk);
      a = lim($signed({{16{r.ka[15]}}, r.ka}), 4000) * 100;
      b = lim($signed({{16{r.kb[15]}}, r.kb}), 4000) * 100;
      rf = r.sel == 0 ? a : r.sel == 1 ? b : r.sel == 2 ? a + b :
        r.sel == 3 ? (r.ps ? b : a) : lim(r.cm, 100000);
      et = r.inv ? -rf : rf;
      c = ~(r.rot ^ rf[31] ^ r.inv);
      chk("torque", et, tq);
      chk("ccw", {31'h0, c && et != 0}, {31'h0, ccw});
      chk("cw", {31'h0, !c && et != 0}, {31'h0, cw});
    end
    run <= 1;
    wr_reg(`TRS_OFS_SRC, 32'h1);
    wr_reg(`TRS_OFS_COMM, 32'h3e8);
    repeat (4) @(posedge mclk);
    chk("running", -32'sd1000, tq);
    rd_reg(`TRS_OFS_TORQUE);
    chk("torque rd", -32'sd1000, rdv);
    rd_reg(`TRS_OFS_STATUS);
    chk("status", 32'h15, rdv);
    run <= 0;
    wr_reg(`TRS_OFS_SRC, 32'h5);
    repeat (4) @(posedge mclk);
    chk("sel 5", 32'h0, tq);
    wr_reg(`TRS_OFS_KEYPAD_A, 32'h64);
    wr_reg(`TRS_OFS_SRC, 32'h0);
    repeat (4) @(posedge mclk);
    chk("main a", -32'sd10000, tq);
    wr_reg(`TRS_OFS_SRC, 32'h100);
    repeat (4) @(posedge mclk);
    chk("main off", 32'h0, tq);
    wr_reg(`TRS_OFS_MODE, 32'h0);
    repeat (4) @(posedge mclk);
    chk("off", 32'h0, tq);
    chk("mode", 32'h0, {31'h0, tma});
    rd_reg(8'h1c);
    chk("rresp", 32'h2, {30'h0, rsp});
    wr_reg(8'h20, 32'h1);
    chk("bresp", 32'h2, {30'h0, rsp});
    rd_reg(`TRS_OFS_COMM);
    chk("comm", 32'h3e8, rdv);
    @(posedge mclk) srst <= 1;
    repeat (3) @(posedge mclk);
    srst <= 0;
    rd_reg(`TRS_OFS_COMM);
    chk("reset", 32'h0, rdv);
    results;
  end
endmodule
`default_nettype wire
